// File: verilog/mwc_consts.svh
// Constants for the write channel: divider counts, widths and reset values
`ifndef MWC_CONSTS_SVH
`define MWC_CONSTS_SVH

// Crystal and derived clock rates in kHz
`define MWC_XTAL_KHZ        24000
`define MWC_WCLK_KHZ        500
`define MWC_MCLK_KHZ        10000
`define MWC_REF_KHZ         1000
// Cycles of mclk per write bit cell and per reference clock
`define MWC_CELL_CYC        (`MWC_MCLK_KHZ / `MWC_WCLK_KHZ)
`define MWC_REF_CYC         (`MWC_MCLK_KHZ / `MWC_REF_KHZ)
// Cell timing in mclk cycles: boundary, mid-cell, precomp shift
`define MWC_POS_BOUND       5'h00
`define MWC_POS_MID         5'h0A
`define MWC_PRECOMP         5'h01
// Pattern width and pulse length
`define MWC_PAT_W           5
`define MWC_PULSE_CYC       4'h2
// Reset values
`define MWC_PAT_RST         5'h00
`define MWC_GAIN_RST        4'h0
`define MWC_SPEED_RST       8'h00

`endif

// File: verilog/mwc_pkg.sv
// Types shared by the write channel
`default_nettype none
package mwc_pkg;
    // Position of a flux transition inside a bit cell
    typedef enum logic [1:0] {
        MWC_TR_NONE,
        MWC_TR_BOUND,
        MWC_TR_MID
    } mwc_tr_t;
    // Precompensation shift applied to a transition
    typedef enum logic [1:0] {
        MWC_PC_NOM,
        MWC_PC_EARLY,
        MWC_PC_LATE
    } mwc_pc_t;
endpackage : mwc_pkg
`default_nettype wire

// File: verilog/mwc_write_channel.sv
// Write channel: serial input, MFM encoder, toggle, heads, supply-low
//
// What this block does
// - Serial write data becomes five-bit parallel pattern.
// - Shift input on the 500 kHz clock.
// - Write clock divided from crystal-rate clock.
// - Encoder makes write pulses, precompensated MFM.
// - Toggle flips when write pulse returns high.
// - Toggle state steers current to coil half.
// - Gap erase stops pulses, current keeps flowing.
// - Erase release resumes MFM pulse generation.
// - Forward head forward, reverse head reverse.
// - High select grounds that head's centre tap.
// - Supply low cuts motors, resets CPU, write.
// - Supply low asynchronously sets the toggle.
// - Set toggle at shutdown stops 1 MHz clock.
// - Supply low gates off both head selects.
// - 1 MHz clock makes motor reference.
// - Selected converter takes speed from data bus.
// - Gain counter cleared, then stepped per pulse.
// - Read head 1 when choice high.
`timescale 1ns/10ps
`include "mwc_consts.svh"
`default_nettype none
module mwc_write_channel #(
    parameter int GAIN_W  = 4,
    parameter int SPEED_W = 8
) (
    // Clock and reset
    input  wire logic               mclk,
    input  wire logic               arst_n,
    // Host serial link
    input  wire logic               ser_data,
    output logic                    write_clock,
    // Encoder control
    input  wire logic               gap_erase_n,
    input  wire logic               write_enable,
    input  wire logic               tape_reverse,
    // Supply monitor
    input  wire logic               supply_low_n,
    output logic                    supply_low_flag,
    output logic                    cpu_reset,
    // Write path outputs
    output logic                    write_pulse_n,
    output logic                    coil_a_drive,
    output logic                    coil_b_drive,
    output logic                    forward_write_head_select,
    output logic                    reverse_write_head_select,
    output logic                    forward_tap_ground_n,
    output logic                    reverse_tap_ground_n,
    output logic [`MWC_PAT_W-1:0]   pattern,
    // Motor reference and speed converter
    output logic                    ref_clock,
    input  wire logic               speed_select,
    input  wire logic               speed_write,
    input  wire logic [SPEED_W-1:0] speed_data,
    output logic [SPEED_W-1:0]      motor_speed,
    // Read gain and read head
    input  wire logic               gain_counter_clear,
    input  wire logic               gain_counter_step_n,
    output logic [GAIN_W-1:0]       read_gain,
    input  wire logic               read_head_choice,
    output logic                    read_head1_on,
    output logic                    read_head2_on
);

    localparam int CELL = `MWC_CELL_CYC;
    localparam int REFH = `MWC_REF_CYC / 2;

    // All checks run on mclk and sleep while reset is low
    default clocking cb_mclk @(posedge mclk);
    endclocking
    default disable iff (!arst_n);

    // Three-stage synchronisers for pin inputs
    logic [2:0] ser_s_r, gap_s_r, sup_s_r, stp_s_r, clr_s_r;
    logic       ser_d_r, gap_d_r, sup_d_r, stp_d_r, clr_d_r;

    // Settle a pin: change only once stages two and three agree
    function automatic logic settle(input logic [2:0] s, input logic d);
        settle = (s[1] == s[2]) ? s[2] : d;
    endfunction : settle

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ser_s_r <= 3'h0;
            gap_s_r <= 3'h7;
            sup_s_r <= 3'h7;
            stp_s_r <= 3'h7;
            clr_s_r <= 3'h0;
        end else begin
            ser_s_r <= {ser_s_r[1:0], ser_data};
            gap_s_r <= {gap_s_r[1:0], gap_erase_n};
            sup_s_r <= {sup_s_r[1:0], supply_low_n};
            stp_s_r <= {stp_s_r[1:0], gain_counter_step_n};
            clr_s_r <= {clr_s_r[1:0], gain_counter_clear};
        end
    end

    // Settled copies of the pins
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ser_d_r <= 1'b0;
            gap_d_r <= 1'b1;
            sup_d_r <= 1'b1;
            stp_d_r <= 1'b1;
            clr_d_r <= 1'b0;
        end else begin
            ser_d_r <= settle(ser_s_r, ser_d_r);
            gap_d_r <= settle(gap_s_r, gap_d_r);
            sup_d_r <= settle(sup_s_r, sup_d_r);
            stp_d_r <= settle(stp_s_r, stp_d_r);
            clr_d_r <= settle(clr_s_r, clr_d_r);
        end
    end

    // cell divider
    // Crystal rate is modelled by mclk; the 500 kHz cell is a divide
    logic [4:0] cell_cnt_r;
    wire        cell_end = (cell_cnt_r == 5'(CELL - 1));
    wire        wclk_level = (cell_cnt_r < 5'(CELL / 2));

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) cell_cnt_r <= 5'h00;
        else         cell_cnt_r <= cell_end ? 5'h00 : cell_cnt_r + 5'h01;
    end

    // five-bit pattern
    // One bit per cell; means the host must hold data a full cell
    logic [`MWC_PAT_W-1:0] shift_r;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n)       shift_r <= `MWC_PAT_RST;
        else if (cell_end) shift_r <= {shift_r[`MWC_PAT_W-2:0], ser_d_r};
    end

    // Pattern bits: [3] previous, [2] current cell, [1] next
    wire bit_prev = shift_r[3];
    wire bit_cur  = shift_r[2];
    wire bit_next = shift_r[1];

    mwc_pkg::mwc_tr_t tr_kind;
    assign tr_kind = bit_cur ? mwc_pkg::MWC_TR_MID :
                     (!bit_prev ? mwc_pkg::MWC_TR_BOUND
                                : mwc_pkg::MWC_TR_NONE);

    // precomp choice
    // A one next to a one on one side moves away from it
    mwc_pkg::mwc_pc_t pc_kind;
    assign pc_kind = (tr_kind != mwc_pkg::MWC_TR_MID) ?
                         mwc_pkg::MWC_PC_NOM :
                     (bit_prev && !bit_next) ? mwc_pkg::MWC_PC_LATE :
                     (!bit_prev && bit_next) ? mwc_pkg::MWC_PC_EARLY :
                                               mwc_pkg::MWC_PC_NOM;

    // Slot within the cell where the pulse begins
    wire [4:0] fire_pos =
        (tr_kind == mwc_pkg::MWC_TR_BOUND) ? `MWC_POS_BOUND :
        (pc_kind == mwc_pkg::MWC_PC_EARLY) ? `MWC_POS_MID - `MWC_PRECOMP :
        (pc_kind == mwc_pkg::MWC_PC_LATE)  ? `MWC_POS_MID + `MWC_PRECOMP :
                                             `MWC_POS_MID;

    wire supply_low = !sup_d_r;

    wire fire = write_enable && gap_d_r && !supply_low &&
                (tr_kind != mwc_pkg::MWC_TR_NONE) &&
                (cell_cnt_r == fire_pos);

    logic [3:0] pulse_cnt_r;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n)               pulse_cnt_r <= 4'h0;
        else if (fire)             pulse_cnt_r <= `MWC_PULSE_CYC;
        else if (pulse_cnt_r != 0) pulse_cnt_r <= pulse_cnt_r - 4'h1;
    end

    logic pulse_n_r;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) pulse_n_r <= 1'b1;
        else         pulse_n_r <= !(fire || pulse_cnt_r > 4'h1);
    end
    logic write_pulse_n_q;
    // Return to high seen one cycle late, so the toggle lags the pin
    wire  pulse_rise = pulse_n_r && !write_pulse_n_q;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) write_pulse_n_q <= 1'b1;
        else         write_pulse_n_q <= pulse_n_r;
    end

    logic tog_r;
    always_ff @(posedge mclk or negedge arst_n or negedge supply_low_n) begin
        if (!arst_n)            tog_r <= 1'b0;
        else if (!supply_low_n) tog_r <= 1'b1;
        else if (pulse_rise)    tog_r <= !tog_r;
    end

    logic [3:0] ref_cnt_r;
    logic       ref_r;
    wire        shutdown = tog_r && supply_low;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ref_cnt_r <= 4'h0;
            ref_r     <= 1'b0;
        end else if (shutdown) begin
            ref_cnt_r <= 4'h0;
            ref_r     <= 1'b0;
        end else if (ref_cnt_r == 4'(REFH - 1)) begin
            ref_cnt_r <= 4'h0;
            ref_r     <= !ref_r;
        end else begin
            ref_cnt_r <= ref_cnt_r + 4'h1;
        end
    end

    // speed converter write
    // Speed only counts while reference runs; no reference, no current
    logic [SPEED_W-1:0] speed_r;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n)                         speed_r <= `MWC_SPEED_RST;
        else if (speed_select && speed_write) speed_r <= speed_data;
    end

    logic [GAIN_W-1:0] gain_r;
    logic              stp_q_r;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            gain_r  <= GAIN_W'(`MWC_GAIN_RST);
            stp_q_r <= 1'b1;
        end else begin
            stp_q_r <= stp_d_r;
            if (clr_d_r)
                gain_r <= GAIN_W'(`MWC_GAIN_RST);
            else if (stp_q_r && !stp_d_r)
                gain_r <= gain_r + GAIN_W'(1);
        end
    end

    wire fwd_sel = write_enable && !tape_reverse && !supply_low;
    wire rev_sel = write_enable &&  tape_reverse && !supply_low;

    // Output drive
    assign write_clock               = wclk_level;
    assign write_pulse_n             = pulse_n_r;
    assign coil_a_drive              = !tog_r && !supply_low && write_enable;
    assign coil_b_drive              =  tog_r && !supply_low && write_enable;
    assign forward_write_head_select = fwd_sel;
    assign reverse_write_head_select = rev_sel;
    assign forward_tap_ground_n      = !fwd_sel;
    assign reverse_tap_ground_n      = !rev_sel;
    assign pattern                   = shift_r;
    assign ref_clock                 = ref_r;
    assign motor_speed               = shutdown ? '0 : speed_r;
    assign supply_low_flag           = supply_low;
    assign cpu_reset                 = supply_low;
    assign read_gain                 = gain_r;
    assign read_head1_on             =  read_head_choice;
    assign read_head2_on             = !read_head_choice;

    // Checks
    // A pulse fired just before erase may still be in flight for two cycles
    AST_ERASE_QUIET: assert property (
        !gap_d_r && !$past(gap_d_r) |=> write_pulse_n)
        else $error("pulse during gap erase");
    AST_SEL_GATED: assert property (
        supply_low |-> !forward_write_head_select
                       && !reverse_write_head_select)
        else $error("head selected in supply low");
    AST_TOG_SET: assert property (
        !supply_low_n |=> tog_r)
        else $error("toggle not set");
    AST_REF_STOP: assert property (
        shutdown |=> !ref_clock)
        else $error("reference still running");
    // A supply drop in the next cycle forces the set and hides the flip
    AST_TOGGLE: assert property (
        (pulse_rise && supply_low_n) ##1 supply_low_n
        |-> tog_r != $past(tog_r))
        else $error("toggle missed");
    AST_SHIFT: assert property (
        cell_end |=> pattern[0] == $past(ser_d_r))
        else $error("shift wrong");
    AST_GAIN_CLR: assert property (
        clr_d_r |=> read_gain == '0)
        else $error("gain not cleared");
    AST_TAP: assert property (
        forward_write_head_select |-> !forward_tap_ground_n)
        else $error("tap not grounded");

    // Pulse shape: two low cycles after a fire, then high again
    sequence s_pulse_low;
        !write_pulse_n ##1 !write_pulse_n;
    endsequence : s_pulse_low

    // Worst case after release: rest of a cell, a quiet cell, a late mid
    sequence s_pulse_soon;
        ##[1:60] !write_pulse_n;
    endsequence : s_pulse_soon

    AST_PULSE_LEN: assert property (
        fire |=> s_pulse_low ##1 write_pulse_n)
        else $error("write pulse shape wrong");
    AST_RESUME: assert property (
        $rose(gap_d_r) && write_enable && !supply_low |-> s_pulse_soon)
        else $error("no pulse after gap release");
    // Erase keeps one coil half driven; only the pulses stop
    AST_ERASE_CURRENT: assert property (
        !gap_d_r && write_enable && !supply_low
        |-> coil_a_drive || coil_b_drive)
        else $error("write current lost in erase");
    AST_COIL_PAIR: assert property (
        write_enable && !supply_low |-> coil_a_drive != coil_b_drive)
        else $error("coil halves not alternating");
    AST_REV_HEAD: assert property (
        write_enable && tape_reverse && !supply_low
        |-> reverse_write_head_select && !forward_write_head_select)
        else $error("wrong head for reverse");
    AST_LOW_WRITE_OFF: assert property (
        supply_low |-> cpu_reset && !coil_a_drive && !coil_b_drive)
        else $error("write path live in supply low");
    AST_REF_RUN: assert property (
        !shutdown && ref_cnt_r == 4'(REFH - 1)
        |=> ref_clock != $past(ref_clock))
        else $error("reference clock stalled");
    AST_GAIN_STEP: assert property (
        !clr_d_r && stp_q_r && !stp_d_r
        |=> read_gain == $past(read_gain) + GAIN_W'(1))
        else $error("gain step missed");
    AST_READ_HEAD: assert property (
        read_head1_on == read_head_choice
        && read_head2_on != read_head_choice)
        else $error("read head choice wrong");

endmodule : mwc_write_channel
`default_nettype wire

// File: bench/mwc_host_model.sv
// Host side model: serial write data paced by the drive's write clock
`timescale 1ns/10ps
`default_nettype none
module mwc_host_model (
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       arst_n,
    // Serial link
    input  wire logic       write_clock,
    input  wire logic [1:0] mode,
    output logic            ser_data
);
    logic wclk_q;

    // one bit per cell
    // New bit on each write clock rise, far from the drive's sample point
    always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            wclk_q   <= 1'b0;
            ser_data <= 1'b0;
        end else begin
            wclk_q <= write_clock;
            if (write_clock && !wclk_q)
                ser_data <= (mode == 2'h2) ? ~ser_data : mode[0];
        end
    end
endmodule : mwc_host_model
`default_nettype wire

// File: bench/mwc_write_channel_tb.sv
// Testbench for the write channel
`timescale 1ns/10ps
`default_nettype none
`define CHK(what, exp, got) begin samples_checked++; \
    if ((got) !== (exp)) begin mismatches++; \
    $display("BAD %s expected %0h seen %0h", what, exp, got); end end
module mwc_write_channel_tb;
    logic mclk, arst_n, ser_data, wclk, gap_n, wen, rev, sl_n;
    logic sl_flag, cpu_rst, wp_n, coil_a, coil_b, fsel, rsel, ftap_n;
    logic rtap_n, refclk, spd_sel, spd_wr, g_clr, g_stp_n, rh, rh1, rh2;
    logic [4:0] pattern;
    logic [7:0] spd_data, spd;
    logic [3:0] gain;
    logic [1:0] mode;
    logic       cnt_en, pn_q, ca_q, rc_q, wc_q;
    int         pulses, flips, ref_falls, wc_rises;
    int         mismatches, samples_checked;

    // Device under test
    mwc_write_channel i_mwc_write_channel (
        .mclk(mclk), .arst_n(arst_n), .ser_data(ser_data),
        .write_clock(wclk), .gap_erase_n(gap_n), .write_enable(wen),
        .tape_reverse(rev), .supply_low_n(sl_n),
        .supply_low_flag(sl_flag), .cpu_reset(cpu_rst),
        .write_pulse_n(wp_n), .coil_a_drive(coil_a),
        .coil_b_drive(coil_b), .forward_write_head_select(fsel),
        .reverse_write_head_select(rsel), .forward_tap_ground_n(ftap_n),
        .reverse_tap_ground_n(rtap_n), .pattern(pattern),
        .ref_clock(refclk), .speed_select(spd_sel),
        .speed_write(spd_wr), .speed_data(spd_data), .motor_speed(spd),
        .gain_counter_clear(g_clr), .gain_counter_step_n(g_stp_n),
        .read_gain(gain), .read_head_choice(rh), .read_head1_on(rh1),
        .read_head2_on(rh2));

    // Host controller on the far side of the serial link
    mwc_host_model i_mwc_host_model (.mclk(mclk), .arst_n(arst_n),
        .write_clock(wclk), .mode(mode), .ser_data(ser_data));

    // 10 MHz clock
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    // Edge counters; counting edges avoids guessing the cell phase
    always @(posedge mclk) begin
        pn_q <= wp_n;
        ca_q <= coil_a;
        rc_q <= refclk;
        wc_q <= wclk;
        if (cnt_en) begin
            if (pn_q && !wp_n) pulses++;
            if (ca_q !== coil_a) flips++;
            if (rc_q && !refclk) ref_falls++;
            if (!wc_q && wclk) wc_rises++;
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask : tick

    // Count events over a whole number of bit cells
    task automatic window(input int cells);
        pulses = 0;
        flips = 0;
        ref_falls = 0;
        wc_rises = 0;
        // Enable by NBA so exactly the next 20*cells edges are counted
        cnt_en <= 1'b1;
        tick(20 * cells);
        cnt_en <= 1'b0;
        tick(1);
    endtask : window

    task automatic end_test(input string name);
        $display("test %s finished", name);
    endtask : end_test

    task automatic test_done;
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : test_done

    // Watchdog, well above the roughly 1800 cycles the tests need
    initial begin
        tick(20000);
        mismatches++;
        test_done;
    end

    initial begin
        {arst_n, gap_n, wen, rev, sl_n, spd_sel, spd_wr} = 7'h34;
        {g_clr, g_stp_n, rh, cnt_en} = 4'h4;
        spd_data = 8'h00;
        mode = 2'h0;
        mismatches = 0;
        samples_checked = 0;
        tick(2);
        arst_n <= 1'b1;
        tick(5);
        `CHK("gain reset", 4'h0, gain)
        `CHK("pulse idle", 1'b1, wp_n)
        // Ones, zeros and alternating streams
        for (int m = 0; m < 3; m++) begin
            mode <= m[1:0];
            tick(160);
            window(10);
            `CHK("pulses", (m == 2) ? 5 : 10, pulses)
            `CHK("flips", pulses, flips)
            `CHK("write clock", 10, wc_rises)
            `CHK("ref clock", 20, ref_falls)
            `CHK("coil pair", 1'b1, coil_a ^ coil_b)
            if (m < 2)
                `CHK("pattern", m[0] ? 5'h1F : 5'h00, pattern)
            else
                `CHK("pattern", 1'b1, pattern == 5'h0A || pattern == 5'h15)
        end
        end_test("stream");
        gap_n <= 1'b0;
        tick(10);
        window(10);
        `CHK("erase pulses", 0, pulses)
        `CHK("erase head", 1'b1, fsel)
        `CHK("erase current", 1'b1, coil_a ^ coil_b)
        gap_n <= 1'b1;
        tick(60);
        window(10);
        `CHK("resume pulses", 5, pulses)
        end_test("erase");
        for (int r = 0; r < 2; r++) begin
            rev <= r[0];
            tick(2);
            `CHK("fwd select", ~r[0], fsel)
            `CHK("rev select", r[0], rsel)
            `CHK("fwd tap", r[0], ftap_n)
            `CHK("rev tap", ~r[0], rtap_n)
            rh <= r[0];
            tick(2);
            `CHK("read head 1", r[0], rh1)
            `CHK("read head 2", ~r[0], rh2)
        end
        end_test("heads");
        {spd_sel, spd_wr, spd_data} <= 10'h3A5;
        tick(1);
        {spd_sel, spd_data} <= 9'h03C;
        tick(2);
        spd_wr <= 1'b0;
        `CHK("speed", 8'hA5, spd)
        // Each pass steps up from zero to a non-zero count, so the clear has work to do
        for (int k = 0; k < 2; k++) begin
            repeat (k ? 5 : 3) begin
                g_stp_n <= 1'b0;
                tick(6);
                g_stp_n <= 1'b1;
                tick(6);
            end
            `CHK("gain", k ? 4'h5 : 4'h3, gain)
            g_clr <= 1'b1;
            tick(6);
            g_clr <= 1'b0;
            tick(6);
            `CHK("gain clear", 4'h0, gain)
        end
        end_test("speed gain");
        sl_n <= 1'b0;
        tick(6);
        `CHK("low flag", 1'b1, sl_flag)
        `CHK("cpu reset", 1'b1, cpu_rst)
        `CHK("speed off", 8'h00, spd)
        `CHK("selects off", 2'h0, {fsel, rsel})
        `CHK("coils off", 2'h0, {coil_a, coil_b})
        window(4);
        `CHK("low pulses", 0, pulses)
        `CHK("ref stopped", 0, ref_falls)
        `CHK("ref low", 1'b0, refclk)
        end_test("supply low");
        test_done;
    end
endmodule : mwc_write_channel_tb
`default_nettype wire
